// File: logic/iptsc_top.sv
// Purpose: Global control, trap flags, priorities and request selection
// Assumes: APB slave with zero wait states; trap inputs are one-cycle pulses
// Notes: Source order: 0 serial event, 1 serial fault, 2 compare five, 3 parallel port
//   Read data is captured in the setup cycle and stands until the next read
//   A trap held high sets its flag again on every cycle
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
//
// Contract
// - Bit 15 of the global control register is a read/write nesting disable resetting to 0.
// - Bits 4 to 1 of the global control register are read/write trap flags resetting to 0.
// - The arithmetic flag sets when an arithmetic overflow trap occurs and stays 0 otherwise.
// - The address and stack flags set when their traps occur and stay 0 otherwise.
// - The oscillator failure flag sets on an oscillator failure trap and stays 0 otherwise.
// - Serial fault priority sits in bits 2 to 0 and serial event priority in bits 6 to 4 of one register.
// - Compare five priority sits in bits 6 to 4 and the rest of its register is unimplemented.
// - Parallel port priority sits in bits 6 to 4 and the rest of its register is unimplemented.
// - Every priority field resets to binary 100.
// - Unimplemented bits read 0 and ignore writes.
module iptsc_top
  import iptsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Trap events from the core
  input wire logic arith_trap_i,
  input wire logic addr_trap_i,
  input wire logic stack_trap_i,
  input wire logic osc_fail_trap_i,
  // Pending sources and the request to the core
  input wire logic [3:0] src_pend_i,
  output logic req_valid_o,
  output logic [1:0] req_id_o,
  output logic [2:0] req_prio_o,
  output logic nesting_disable_o,
  output logic irq_o
);
  // Register state
  logic nesting_disable;
  logic [3:0] trap_flags;
  logic [2:0] serial_event_priority;
  logic [2:0] serial_fault_priority;
  logic [2:0] compare_five_priority_field;
  logic [2:0] parallel_port_priority_field;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [31:0] prdata;
  logic pslverr;
  logic req_valid;
  logic [1:0] req_id;
  logic [2:0] req_prio;
  logic irq;

  // Next values
  logic next_nesting_disable;
  logic [3:0] next_trap_flags;
  logic [2:0] next_serial_event_priority;
  logic [2:0] next_serial_fault_priority;
  logic [2:0] next_compare_five_priority_field;
  logic [2:0] next_parallel_port_priority_field;
  logic [3:0] next_irq_status;
  logic [3:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_req_valid;
  logic [1:0] next_req_id;
  logic [2:0] next_req_prio;
  logic next_irq;

  // Bus decode and helpers
  logic setup;
  logic wr;
  logic rd;
  logic lo_en;
  logic hi_en;
  logic mapped;
  logic [3:0] trap_evt;
  logic [15:0] global_rd;
  logic [15:0] serial_rd;
  logic [15:0] compare_rd;
  logic [15:0] parallel_rd;
  logic [15:0] wmask;
  logic [3:0] sw_trap_flags;
  logic [3:0] sw_irq_status;
  logic pready;
  logic next_pready;
  logic hit_global;
  logic hit_status;
  logic hit_mask;
  logic wr_lo;
  logic wr_hi;
  iptsc_sel_if sel_bus ();

  // Highest pending nonzero priority, lowest index on ties
  iptsc_select u_select (
    .s(sel_bus.sel)
  );

  // Selector inputs in source order
  assign sel_bus.pend = src_pend_i;
  assign sel_bus.prio = {parallel_port_priority_field, compare_five_priority_field,
                         serial_fault_priority, serial_event_priority};

  // APB phase decode
  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = setup && !pwrite_i;
  assign lo_en = pstrb_i[0];
  assign hi_en = pstrb_i[1];
  assign wmask = {{8{hi_en}}, {8{lo_en}}};
  assign trap_evt = {arith_trap_i, addr_trap_i, stack_trap_i, osc_fail_trap_i};
  assign hit_global = paddr_i == OFF_GLOBAL_CONTROL;
  assign hit_status = paddr_i == OFF_IRQ_STATUS;
  assign hit_mask = paddr_i == OFF_IRQ_MASK;
  assign wr_lo = wr && lo_en;
  assign wr_hi = wr && hi_en;

  // Read views with unimplemented bits forced low
  always_comb begin
    global_rd = 16'h0000;
    global_rd[BIT_NESTING_DISABLE] = nesting_disable;
    global_rd[BIT_ARITH:BIT_OSC] = trap_flags;
    serial_rd = 16'h0000;
    serial_rd[FLD_HIGH_LSB +: 3] = serial_event_priority;
    serial_rd[FLD_LOW_LSB +: 3] = serial_fault_priority;
    compare_rd = 16'h0000;
    compare_rd[FLD_HIGH_LSB +: 3] = compare_five_priority_field;
    parallel_rd = 16'h0000;
    parallel_rd[FLD_HIGH_LSB +: 3] = parallel_port_priority_field;
  end

  always_comb begin
    mapped = 1'b1;
    unique case (paddr_i)
      OFF_GLOBAL_CONTROL: next_prdata = {16'h0000, global_rd};
      OFF_SERIAL_PRIORITY: next_prdata = {16'h0000, serial_rd};
      OFF_COMPARE_PRIORITY: next_prdata = {16'h0000, compare_rd};
      OFF_PARALLEL_PRIORITY: next_prdata = {16'h0000, parallel_rd};
      OFF_PENDING: next_prdata = {28'h0000000, src_pend_i};
      OFF_IRQ_STATUS: next_prdata = {28'h0000000, irq_status};
      OFF_IRQ_MASK: next_prdata = {28'h0000000, irq_mask};
      OFF_PRESENT: next_prdata = {26'h0000000, req_valid, req_prio, req_id};
      default: begin
        mapped = 1'b0;
        next_prdata = 32'h00000000;
      end
    endcase
    if (!rd) begin
      next_prdata = prdata;
    end
    next_pslverr = setup ? !mapped : 1'b0;
    next_pready = 1'b1;
  end

  // Control group: software view of nesting disable and trap flags
  always_comb begin
    next_nesting_disable = nesting_disable;
    sw_trap_flags = trap_flags;
    if (wr_hi && hit_global && GLOBAL_WMASK[BIT_NESTING_DISABLE]) begin
      next_nesting_disable = pwdata_i[BIT_NESTING_DISABLE];
    end
    if (wr_lo && hit_global) begin
      sw_trap_flags = pwdata_i[BIT_ARITH:BIT_OSC];
    end
  end

  // Per trap bit: set beats a software clear in the same cycle
  for (genvar g = 0; g < $bits(trap_evt); g++) begin : g_trap
    assign next_trap_flags[g] = sw_trap_flags[g] | trap_evt[g];
    assign next_irq_status[g] = sw_irq_status[g] | trap_evt[g];
  end

  // Priority group: only the implemented fields take write data
  always_comb begin
    next_serial_event_priority = serial_event_priority;
    next_serial_fault_priority = serial_fault_priority;
    next_compare_five_priority_field = compare_five_priority_field;
    next_parallel_port_priority_field = parallel_port_priority_field;
    if (wr_lo) begin
      unique case (paddr_i)
        OFF_SERIAL_PRIORITY: begin
          next_serial_event_priority = pwdata_i[FLD_HIGH_LSB +: 3];
          next_serial_fault_priority = pwdata_i[FLD_LOW_LSB +: 3];
        end
        OFF_COMPARE_PRIORITY: begin
          next_compare_five_priority_field = pwdata_i[FLD_HIGH_LSB +: 3];
        end
        OFF_PARALLEL_PRIORITY: begin
          next_parallel_port_priority_field = pwdata_i[FLD_HIGH_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
  end

  // Interrupt group: status is write one to clear
  always_comb begin
    next_irq_mask = irq_mask;
    sw_irq_status = irq_status;
    if (wr_lo && hit_status) begin
      sw_irq_status = irq_status & ~(pwdata_i[3:0] & wmask[3:0]);
    end
    if (wr_lo && hit_mask) begin
      next_irq_mask = pwdata_i[3:0];
    end
  end

  // Level interrupt from unmasked status
  always_comb begin
    next_irq = |(next_irq_status & irq_mask);
  end

  // Request to the core, one cycle behind the pending levels
  always_comb begin
    next_req_valid = sel_bus.found;
    next_req_id = sel_bus.win_id;
    next_req_prio = sel_bus.win_prio;
  end

  // Control group state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      nesting_disable <= 1'b0;
      trap_flags <= TRAP_RESET;
    end else begin
      nesting_disable <= next_nesting_disable;
      trap_flags <= next_trap_flags;
    end
  end

  // Priority group state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      serial_event_priority <= PRIO_RESET;
      serial_fault_priority <= PRIO_RESET;
      compare_five_priority_field <= PRIO_RESET;
      parallel_port_priority_field <= PRIO_RESET;
    end else begin
      serial_event_priority <= next_serial_event_priority;
      serial_fault_priority <= next_serial_fault_priority;
      compare_five_priority_field <= next_compare_five_priority_field;
      parallel_port_priority_field <= next_parallel_port_priority_field;
    end
  end

  // Interrupt group state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_status <= 4'h0;
      irq_mask <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

  // Bus response state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b1;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= next_pready;
    end
  end

  // Request state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_valid <= 1'b0;
      req_id <= 2'h0;
      req_prio <= PRIO_OFF;
    end else begin
      req_valid <= next_req_valid;
      req_id <= next_req_id;
      req_prio <= next_req_prio;
    end
  end

  assign prdata_o = prdata;
  assign pslverr_o = pslverr;
  assign pready_o = pready;
  assign req_valid_o = req_valid;
  assign req_id_o = req_id;
  assign req_prio_o = req_prio;
  assign nesting_disable_o = nesting_disable;
  assign irq_o = irq;
endmodule // iptsc_top

// File: logic/iptsc_pkg.sv
// Purpose: Constants for the interrupt priority and trap status block
// Assumes: APB slave, 32-bit data, 16-bit registers in the low half
// Notes: Offsets are byte addresses
package iptsc_pkg;
  localparam logic [11:0] OFF_GLOBAL_CONTROL = 12'h000;
  localparam logic [11:0] OFF_SERIAL_PRIORITY = 12'h004;
  localparam logic [11:0] OFF_COMPARE_PRIORITY = 12'h008;
  localparam logic [11:0] OFF_PARALLEL_PRIORITY = 12'h00C;
  localparam logic [11:0] OFF_PENDING = 12'h010;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h014;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
  localparam logic [11:0] OFF_PRESENT = 12'h01C;
  localparam int BIT_NESTING_DISABLE = 15;
  localparam int BIT_ARITH = 4;
  localparam int BIT_ADDR = 3;
  localparam int BIT_STACK = 2;
  localparam int BIT_OSC = 1;
  localparam int FLD_HIGH_LSB = 4;
  localparam int FLD_LOW_LSB = 0;
  localparam int NUM_SRC = 4;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [15:0] GLOBAL_WMASK = 16'h801E;
  localparam logic [3:0] TRAP_RESET = 4'h0;
endpackage : iptsc_pkg

// File: logic/iptsc_sel_if.sv
// Purpose: Carries source levels and priorities to the selector
// Assumes: One clock domain
// Notes: Combinational result
`timescale 1ns/10ps
interface iptsc_sel_if;
  logic [3:0] pend;
  logic [11:0] prio;
  logic found;
  logic [1:0] win_id;
  logic [2:0] win_prio;
  modport ctrl (output pend, output prio, input found, input win_id, input win_prio);
  modport sel (input pend, input prio, output found, output win_id, output win_prio);
endinterface : iptsc_sel_if

// File: logic/iptsc_select.sv
// Purpose: Picks the pending source of highest nonzero priority
// Assumes: Lowest index wins ties
// Notes: Purely combinational
`timescale 1ns/10ps
module iptsc_select
  import iptsc_pkg::*;
(
  iptsc_sel_if.sel s
);
  always_comb begin
    s.found = 1'b0;
    s.win_id = 2'h0;
    s.win_prio = PRIO_OFF;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      // Greater-or-equal from the top keeps lowest index on ties
      if (s.pend[i] && s.prio[i*3 +: 3] != PRIO_OFF && s.prio[i*3 +: 3] >= s.win_prio) begin
        s.found = 1'b1;
        s.win_id = 2'(i);
        s.win_prio = s.prio[i*3 +: 3];
      end
    end
  end
endmodule // iptsc_select

// File: sim/iptsc_chk.sv
// Purpose: Port checks for the priority and trap block
// Assumes: Zero wait state reads, read data taken at setup
// Notes: Attached by bind below
`timescale 1ns/10ps
module iptsc_chk
  import iptsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic arith_trap_i,
  input wire logic addr_trap_i,
  input wire logic stack_trap_i,
  input wire logic osc_fail_trap_i,
  input wire logic [3:0] src_pend_i,
  input wire logic req_valid_o,
  input wire logic [1:0] req_id_o,
  input wire logic [2:0] req_prio_o,
  input wire logic nesting_disable_o
);
  logic rd_glob;
  logic rd_acc;
  assign rd_glob = psel_i && !penable_i && !pwrite_i && paddr_i == OFF_GLOBAL_CONTROL;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_nest_write: assert property (
    psel_i && penable_i && pwrite_i && paddr_i == OFF_GLOBAL_CONTROL && pstrb_i[1]
    |=> nesting_disable_o == $past(pwdata_i[BIT_NESTING_DISABLE])) else $error("nesting bit not written");
  a_arith_flag: assert property (
    rd_glob && $past(arith_trap_i) |=> prdata_o[BIT_ARITH]) else $error("arith flag not set");
  a_addr_stack: assert property (
    rd_glob |=> (prdata_o[BIT_ADDR] || !$past(addr_trap_i, 2)) && (prdata_o[BIT_STACK] || !$past(stack_trap_i, 2)))
    else $error("addr or stack flag not set");
  a_osc_flag: assert property (
    rd_glob && $past(osc_fail_trap_i) |=> prdata_o[BIT_OSC]) else $error("osc flag not set");
  a_glob_unimpl: assert property (
    rd_acc && paddr_i == OFF_GLOBAL_CONTROL |-> (prdata_o & 32'hFFFF7FE1) == 32'h0) else $error("global spare bits");
  a_serial_unimpl: assert property (
    rd_acc && paddr_i == OFF_SERIAL_PRIORITY |-> (prdata_o & 32'hFFFFFF88) == 32'h0) else $error("serial spare bits");
  a_single_unimpl: assert property (
    rd_acc && (paddr_i == OFF_COMPARE_PRIORITY || paddr_i == OFF_PARALLEL_PRIORITY)
    |-> (prdata_o & 32'hFFFFFF8F) == 32'h0) else $error("priority spare bits");
  a_prio_nonzero: assert property (
    req_valid_o |-> req_prio_o != PRIO_OFF) else $error("zero priority presented");
  a_win_pending: assert property (
    req_valid_o |-> ($past(src_pend_i) & (4'h1 << req_id_o)) != 4'h0) else $error("winner not pending");
  a_idle_quiet: assert property (
    $past(src_pend_i) == 4'h0 |-> !req_valid_o) else $error("request with none pending");
  cover property (req_valid_o && req_prio_o == 3'h7);
  cover property (rd_glob ##1 prdata_o[BIT_ARITH]);
  cover property (nesting_disable_o);
endmodule // iptsc_chk

bind iptsc_top iptsc_chk u_chk (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i),
  .prdata_o(prdata_o),
  .arith_trap_i(arith_trap_i),
  .addr_trap_i(addr_trap_i),
  .stack_trap_i(stack_trap_i),
  .osc_fail_trap_i(osc_fail_trap_i),
  .src_pend_i(src_pend_i),
  .req_valid_o(req_valid_o),
  .req_id_o(req_id_o),
  .req_prio_o(req_prio_o),
  .nesting_disable_o(nesting_disable_o)
);

// File: sim/iptsc_core_model.sv
// Purpose: Core side trap source
// Assumes: Called just after a clock edge
// Notes: Bit order arith, addr, stack, osc
`timescale 1ns/10ps
module iptsc_core_model (
  input wire logic clk_i,
  output logic [3:0] trap_o
);
  initial trap_o = 4'h0;
  // One-cycle trap pulse
  task automatic fire(input logic [3:0] t);
    trap_o <= t;
    @(posedge clk_i);
    trap_o <= 4'h0;
  endtask
endmodule // iptsc_core_model

// File: sim/iptsc_top_tb.sv
// Purpose: Self-checking bench for the priority and trap block
// Assumes: Zero wait state slave
// Notes: Seeded random priorities and pending sets
`timescale 1ns/10ps
module iptsc_top_tb;
  import iptsc_pkg::*;
  logic clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
  logic [11:0] paddr_i = 0, p;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hF, src_pend_i = 4'h0, pend, traps;
  logic pready_o, pslverr_o, arith_trap_i, addr_trap_i, stack_trap_i, osc_fail_trap_i;
  logic req_valid_o, nesting_disable_o, irq_o;
  logic [1:0] req_id_o;
  logic [2:0] req_prio_o;
  logic [15:0] hc [3] = '{16'h924F, 16'hFC0B, 16'h000F};
  logic [11:0] offs [4] = '{OFF_GLOBAL_CONTROL, OFF_SERIAL_PRIORITY, OFF_COMPARE_PRIORITY, OFF_PARALLEL_PRIORITY};
  logic [31:0] rst_v [4] = '{32'h0, 32'h44, 32'h40, 32'h40};
  logic [31:0] ones_v [4] = '{32'h801E, 32'h77, 32'h70, 32'h70};
  int failures = 0, samples_checked = 0, cycles = 0;
  assign {arith_trap_i, addr_trap_i, stack_trap_i, osc_fail_trap_i} = traps;
  always #25 clk_i = ~clk_i;
  iptsc_top uut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .arith_trap_i(arith_trap_i),
    .addr_trap_i(addr_trap_i),
    .stack_trap_i(stack_trap_i),
    .osc_fail_trap_i(osc_fail_trap_i),
    .src_pend_i(src_pend_i),
    .req_valid_o(req_valid_o),
    .req_id_o(req_id_o),
    .req_prio_o(req_prio_o),
    .nesting_disable_o(nesting_disable_o),
    .irq_o(irq_o)
  );
  iptsc_core_model u_core (.clk_i(clk_i), .trap_o(traps));
  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      test_done();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Expected {valid, prio, id}, lowest index wins ties
  function automatic logic [5:0] win(input logic [11:0] pr, input logic [3:0] pe);
    logic [5:0] b;
    b = 6'h0;
    for (int i = 0; i < 4; i++)
      if (pe[i] && pr[3*i+:3] > b[4:2]) b = {1'b1, pr[3*i+:3], 2'(i)};
    return b;
  endfunction
  initial begin
    void'($urandom(12481));
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, offs[k], 32'h0, 4'hF);
      check("reset value", rd, rst_v[k]);
      apb(1'b1, offs[k], 32'hFFFFFFFF, 4'hF);
      apb(1'b0, offs[k], 32'h0, 4'hF);
      check("all ones", rd, ones_v[k]);
    end
    check("nesting out", {31'h0, nesting_disable_o}, 32'h1);
    apb(1'b1, OFF_GLOBAL_CONTROL, 32'h0, 4'h1);
    apb(1'b0, OFF_GLOBAL_CONTROL, 32'h0, 4'hF);
    check("low strobe", rd, 32'h8000);
    apb(1'b1, OFF_GLOBAL_CONTROL, 32'h0, 4'hF);
    $display("test registers done");
    apb(1'b1, OFF_IRQ_MASK, 32'hF, 4'hF);
    for (int i = 0; i < 4; i++) begin
      // Trap lands on the edge just before the read setup
      fork
        u_core.fire(4'h1 << i);
        apb(1'b0, OFF_GLOBAL_CONTROL, 32'h0, 4'hF);
      join
      check("trap flag", rd, 32'h2 << i);
      apb(1'b1, OFF_GLOBAL_CONTROL, 32'h0, 4'hF);
    end
    apb(1'b0, OFF_IRQ_STATUS, 32'h0, 4'hF);
    check("irq status", rd, 32'hF);
    check("irq raised", {31'h0, irq_o}, 32'h1);
    apb(1'b1, OFF_IRQ_STATUS, 32'hF, 4'hF);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0, 4'hF);
    check("status cleared", rd, 32'h0);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h0, 4'hF);
    u_core.fire(4'h8);
    repeat (3) @(posedge clk_i);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0, 4'hF);
    check("masked status", rd, 32'h8);
    $display("test traps done");
    for (int k = 0; k < 24; k++) begin
      p = 12'($urandom);
      pend = 4'($urandom);
      if (k < 3) {p, pend} = hc[k];
      apb(1'b1, OFF_SERIAL_PRIORITY, {25'h0, p[2:0], 1'b0, p[5:3]}, 4'hF);
      apb(1'b1, OFF_COMPARE_PRIORITY, {25'h0, p[8:6], 4'h0}, 4'hF);
      apb(1'b1, OFF_PARALLEL_PRIORITY, {25'h0, p[11:9], 4'h0}, 4'hF);
      src_pend_i <= pend;
      repeat (2) @(posedge clk_i);
      check("winner", {26'h0, req_valid_o, req_valid_o ? {req_prio_o, req_id_o} : 5'h0}, {26'h0, win(p, pend)});
      apb(1'b0, OFF_PRESENT, 32'h0, 4'hF);
      check("present", rd, {26'h0, win(p, pend)});
      apb(1'b0, OFF_PENDING, 32'h0, 4'hF);
      check("pending", rd, {28'h0, pend});
    end
    $display("test selection done");
    apb(1'b0, 12'h020, 32'h0, 4'hF);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    $display("test unmapped done");
    test_done();
  end
endmodule // iptsc_top_tb
